// ==== shared/ecl_defs.vh ====
// Summary of operation
// - load bus parameter word into bus logic
// - bit 0 sets back-to-back capable flag
// - bit 1 sets user features flag
// - bit 2 gives third base address type
// - bits 6:3 become min grant 4:1
// - bits 10:7 become max latency 5:2
// - bits 15:11 feed wake and d1/d2 support
// - power word readable through power register
// - alternate address in words 10h-12h, low byte first
// - maker id word has no function
// - mac side loads first, bridge after
// - power word holds d0/d1, d2, d3 fields
// - scale 0b11 for selector 3 or 7, else 0b01
// - bus word at 0Ch, power word at 19h
`ifndef ECL_DEFS_VH
`define ECL_DEFS_VH
`define ECL_AW 6
`define ECL_OFS_MAC_FIRST 6'h03
`define ECL_OFS_MAC_LAST 6'h0B
`define ECL_OFS_DATE 6'h04
`define ECL_OFS_MAKER 6'h07
`define ECL_OFS_BUS_PARAM 6'h0C
`define ECL_OFS_ALT_ADDR0 6'h10
`define ECL_OFS_ALT_ADDR2 6'h12
`define ECL_OFS_SUB_VENDOR 6'h17
`define ECL_OFS_SUB_ID 6'h18
`define ECL_OFS_POWER 6'h19
`define ECL_OFS_CHECKSUM 6'h1F
`define ECL_DATE_DAY_LSB 0
`define ECL_DATE_MONTH_LSB 5
`define ECL_DATE_YEAR_LSB 9
`define ECL_SCALE_MILLI 2'h3
`define ECL_SCALE_DECI 2'h1
`define ECL_WORD_RESET 16'h0000
`define ECL_REG_STATUS 4'h0
`define ECL_REG_BUS_PARAM 4'h1
`define ECL_REG_POWER 4'h2
`define ECL_REG_SELECT 4'h3
`define ECL_REG_PM_DATA 4'h4
`define ECL_REG_DATE 4'h5
`define ECL_REG_MAKER 4'h6
`define ECL_REG_ALT0 4'h7
`define ECL_REG_ALT1 4'h8
`define ECL_REG_ALT2 4'h9
`define ECL_REG_CTRL 4'hA
`endif

// ==== rtl/ecl_word_mem.v ====
`timescale 1ns/10ps
`include "ecl_defs.vh"
module ecl_word_mem #(
  parameter AW = 6,
  parameter DW = 16
) (
  input wire clk,
  input wire ce,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data_q
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule

// ==== rtl/ecl_loader.v ====
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "ecl_defs.vh"
module ecl_loader (
  input wire CLK,
  input wire RESET_N,
  input wire CE,
  input wire START,
  output reg EE_REQ,
  output reg [5:0] EE_ADDR,
  input wire EE_ACK,
  input wire [15:0] EE_DATA,
  input wire [3:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [15:0] REG_RDATA,
  output reg LOAD_DONE,
  output reg CHECKSUM_OK,
  output reg BACK_TO_BACK_CAPABLE,
  output reg USER_FEATURES_FLAG,
  output reg BELOW_ONE_MB_MAP,
  output reg [7:0] MIN_GRANT_FIELD,
  output reg [7:0] MAX_LATENCY_FIELD,
  output reg [4:0] WAKE_SUPPORT_FIELD,
  output reg D1_SUPPORT,
  output reg D2_SUPPORT,
  output reg [7:0] POWER_DATA,
  output reg [1:0] POWER_DATA_SCALE
);
  // ---------------------------------------------------------------
  // load sequencer
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_REQ = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_DONE = 3'h3;

  reg [2:0] state_q;
  reg [5:0] addr_q;
  reg [15:0] xor_q;
  reg [15:0] bus_param_word_q;
  reg [15:0] power_budget_word_q;
  reg [15:0] date_q;
  reg [15:0] maker_id_word_q;
  reg [3:0] power_data_selector_q;
  reg done_q;
  reg ack_s1_q;
  reg ack_s2_q;
  reg ack_s3_q;
  reg ack_seen_q;
  reg [15:0] data_s1_q;
  reg [15:0] data_s2_q;
  wire ack_rise;
  wire [15:0] alt0_word;
  wire [15:0] alt1_word;
  wire [15:0] alt2_word;
  wire [3:0] mem_raddr;
  wire [15:0] mem_rdata;

  // ack is a pin handshake; data held stable while ack high
  assign ack_rise = ack_s2_q & ack_s3_q & ~ack_seen_q;

  always @(posedge CLK) begin
    if (!RESET_N) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      data_s1_q <= `ECL_WORD_RESET;
      data_s2_q <= `ECL_WORD_RESET;
    end else if (CE) begin
      ack_s1_q <= EE_ACK;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      data_s1_q <= EE_DATA;
      data_s2_q <= data_s1_q;
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
      addr_q <= `ECL_OFS_MAC_FIRST;
      xor_q <= `ECL_WORD_RESET;
      bus_param_word_q <= `ECL_WORD_RESET;
      power_budget_word_q <= `ECL_WORD_RESET;
      date_q <= `ECL_WORD_RESET;
      maker_id_word_q <= `ECL_WORD_RESET;
      done_q <= 1'b0;
      ack_seen_q <= 1'b0;
      EE_REQ <= 1'b0;
      EE_ADDR <= 6'h00;
      CHECKSUM_OK <= 1'b0;
    end else if (CE) begin
      if (!(ack_s2_q & ack_s3_q)) begin
        ack_seen_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (START) begin
            addr_q <= `ECL_OFS_MAC_FIRST;
            xor_q <= `ECL_WORD_RESET;
            state_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          // mac words 03h-0Bh walk first, bridge words follow
          EE_ADDR <= addr_q;
          EE_REQ <= 1'b1;
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (ack_rise) begin
            ack_seen_q <= 1'b1;
            EE_REQ <= 1'b0;
            if (addr_q != `ECL_OFS_CHECKSUM) begin
              xor_q <= xor_q ^ data_s2_q;
            end
            case (addr_q)
              `ECL_OFS_BUS_PARAM: bus_param_word_q <= data_s2_q;
              `ECL_OFS_POWER: power_budget_word_q <= data_s2_q;
              `ECL_OFS_DATE: date_q <= data_s2_q;
              `ECL_OFS_MAKER: maker_id_word_q <= data_s2_q;
              default: begin
              end
            endcase
            if (addr_q == `ECL_OFS_CHECKSUM) begin
              CHECKSUM_OK <= (xor_q == data_s2_q);
              done_q <= 1'b1;
              state_q <= ST_DONE;
            end else begin
              addr_q <= addr_q + 6'h01;
              state_q <= ST_REQ;
            end
          end
        end
        ST_DONE: begin
          EE_REQ <= 1'b0;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // word image for alternate station address
  // ---------------------------------------------------------------
  wire mem_we;
  assign mem_we = (state_q == ST_WAIT) & ack_rise;
  // address taken on every enabled clock, read strobe or not, so data stand in the next cycle
  assign mem_raddr = REG_ADDR - `ECL_REG_ALT0;

  ecl_word_mem #(
    .AW(`ECL_AW),
    .DW(16)
  ) u_mem (
    .clk(CLK),
    .ce(CE),
    .wr_en(mem_we),
    .wr_addr(addr_q),
    .wr_data(data_s2_q),
    .rd_addr({2'b01, mem_raddr}),
    .rd_data_q(mem_rdata)
  );
  // alt_station_address: byte 2n low half, byte 2n+1 high half
  assign alt0_word = mem_rdata;
  assign alt1_word = mem_rdata;
  assign alt2_word = mem_rdata;

  // ---------------------------------------------------------------
  // configuration space fields
  // ---------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RESET_N) begin
      LOAD_DONE <= 1'b0;
      BACK_TO_BACK_CAPABLE <= 1'b0;
      USER_FEATURES_FLAG <= 1'b0;
      BELOW_ONE_MB_MAP <= 1'b0;
      MIN_GRANT_FIELD <= 8'h00;
      MAX_LATENCY_FIELD <= 8'h00;
      WAKE_SUPPORT_FIELD <= 5'h00;
      D1_SUPPORT <= 1'b0;
      D2_SUPPORT <= 1'b0;
      POWER_DATA <= 8'h00;
      POWER_DATA_SCALE <= 2'h0;
    end else if (CE) begin
      LOAD_DONE <= done_q;
      if (done_q) begin
        BACK_TO_BACK_CAPABLE <= bus_param_word_q[0];
        USER_FEATURES_FLAG <= bus_param_word_q[1];
        BELOW_ONE_MB_MAP <= bus_param_word_q[2];
        MIN_GRANT_FIELD <= {3'h0, bus_param_word_q[6:3], 1'b0};
        MAX_LATENCY_FIELD <= {2'h0, bus_param_word_q[10:7], 2'h0};
        WAKE_SUPPORT_FIELD <= bus_param_word_q[15:11];
        D1_SUPPORT <= bus_param_word_q[11];
        D2_SUPPORT <= bus_param_word_q[12];
        case (power_data_selector_q)
          4'h0, 4'h1, 4'h4, 4'h5: POWER_DATA <= {3'h0, power_budget_word_q[5:1]};
          4'h2, 4'h6: POWER_DATA <= {3'h0, power_budget_word_q[10:6]};
          4'h3, 4'h7: POWER_DATA <= {3'h0, power_budget_word_q[15:11]};
          default: POWER_DATA <= 8'h00;
        endcase
        if (power_data_selector_q == 4'h3 || power_data_selector_q == 4'h7) begin
          POWER_DATA_SCALE <= `ECL_SCALE_MILLI;
        end else begin
          POWER_DATA_SCALE <= `ECL_SCALE_DECI;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RESET_N) begin
      power_data_selector_q <= 4'h0;
    end else if (CE) begin
      if (REG_WR && REG_ADDR == `ECL_REG_SELECT) begin
        power_data_selector_q <= REG_WDATA[3:0];
      end
    end
  end

  reg [3:0] rd_addr_q;
  reg rd_q;
  always @(posedge CLK) begin
    if (!RESET_N) begin
      rd_addr_q <= 4'h0;
      rd_q <= 1'b0;
    end else if (CE) begin
      rd_addr_q <= REG_ADDR;
      rd_q <= REG_RD;
    end
  end

  always @* begin
    REG_RDATA = 16'h0000;
    if (rd_q) begin
      case (rd_addr_q)
        `ECL_REG_STATUS: REG_RDATA = {14'h0, CHECKSUM_OK, LOAD_DONE};
        `ECL_REG_BUS_PARAM: REG_RDATA = done_q ? bus_param_word_q : 16'h0000;
        `ECL_REG_POWER: REG_RDATA = done_q ? power_budget_word_q : 16'h0000;
        `ECL_REG_SELECT: REG_RDATA = {12'h0, power_data_selector_q};
        `ECL_REG_PM_DATA: REG_RDATA = {6'h0, POWER_DATA_SCALE, POWER_DATA};
        `ECL_REG_DATE: REG_RDATA = date_q;
        `ECL_REG_MAKER: REG_RDATA = maker_id_word_q;
        `ECL_REG_ALT0: REG_RDATA = alt0_word;
        `ECL_REG_ALT1: REG_RDATA = alt1_word;
        `ECL_REG_ALT2: REG_RDATA = alt2_word;
        default: REG_RDATA = 16'h0000;
      endcase
    end
  end
endmodule

// ==== tb/ecl_ee_model.sv ====
`timescale 1ns/10ps
module ecl_ee_model (
  input wire CLK,
  input wire SLOW,
  input wire EE_REQ,
  input wire [5:0] EE_ADDR,
  output reg EE_ACK,
  output reg [15:0] EE_DATA
);
  // ----
  // word store
  // ----
  reg [15:0] mem [0:63];
  reg [2:0] wait_q;
  initial begin
    EE_ACK = 1'h0;
    EE_DATA = 16'h0000;
    wait_q = 3'h0;
  end
  // data flips once released
  always @(posedge CLK) begin
    if (EE_REQ && !EE_ACK && wait_q >= {SLOW, 2'h0}) begin
      EE_ACK <= 1'h1;
      EE_DATA <= mem[EE_ADDR];
    end else if (!EE_REQ && EE_ACK) begin
      EE_ACK <= 1'h0;
      EE_DATA <= ~EE_DATA;
    end
    wait_q <= (EE_REQ && !EE_ACK) ? wait_q + 3'h1 : 3'h0;
  end
endmodule

// ==== tb/ecl_loader_asserts.sv ====
`timescale 1ns/10ps
module ecl_loader_asserts (
  input wire CLK,
  input wire RESET_N,
  input wire CE,
  input wire EE_REQ,
  input wire [5:0] EE_ADDR,
  input wire EE_ACK,
  input wire [15:0] EE_DATA,
  input wire [3:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [15:0] REG_RDATA,
  input wire LOAD_DONE,
  input wire BACK_TO_BACK_CAPABLE,
  input wire USER_FEATURES_FLAG,
  input wire BELOW_ONE_MB_MAP,
  input wire [7:0] MIN_GRANT_FIELD,
  input wire [7:0] MAX_LATENCY_FIELD,
  input wire [4:0] WAKE_SUPPORT_FIELD,
  input wire D1_SUPPORT,
  input wire D2_SUPPORT,
  input wire [7:0] POWER_DATA,
  input wire [1:0] POWER_DATA_SCALE
);
  // ----
  // shadow of loaded word
  // ----
  reg [15:0] bw_q;
  reg [3:0] sel_q;
  reg [5:0] ad_q;
  always @(posedge CLK) begin
    if (!RESET_N) begin
      bw_q <= 16'h0000;
      sel_q <= 4'h0;
    end else begin
      if (EE_REQ && EE_ACK && EE_ADDR == 6'h0C) bw_q <= EE_DATA;
      if (CE && REG_WR && REG_ADDR == 4'h3) sel_q <= REG_WDATA[3:0];
    end
    if (EE_REQ) ad_q <= EE_ADDR;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_held;
    LOAD_DONE [*2];
  endsequence
  property p_flags;
    s_held |-> BACK_TO_BACK_CAPABLE == bw_q[0] && USER_FEATURES_FLAG == bw_q[1]
      && BELOW_ONE_MB_MAP == bw_q[2];
  endproperty
  a_flags: assert property (p_flags) else $error("status flags wrong");
  property p_grant;
    s_held |-> MIN_GRANT_FIELD == {3'h0, bw_q[6:3], 1'h0};
  endproperty
  a_grant: assert property (p_grant) else $error("min grant wrong");
  property p_lat;
    s_held |-> MAX_LATENCY_FIELD == {2'h0, bw_q[10:7], 2'h0};
  endproperty
  a_lat: assert property (p_lat) else $error("max latency wrong");
  property p_wake;
    s_held |-> WAKE_SUPPORT_FIELD == bw_q[15:11] && D1_SUPPORT == bw_q[11]
      && D2_SUPPORT == bw_q[12];
  endproperty
  a_wake: assert property (p_wake) else $error("wake fields wrong");
  property p_scale;
    LOAD_DONE && $past(LOAD_DONE, 2) && sel_q == $past(sel_q, 2) |->
      POWER_DATA_SCALE == ((sel_q == 4'h3 || sel_q == 4'h7) ? 2'h3 : 2'h1);
  endproperty
  a_scale: assert property (p_scale) else $error("scale wrong");
  property p_zero;
    !LOAD_DONE |-> MIN_GRANT_FIELD == 8'h00 && MAX_LATENCY_FIELD == 8'h00
      && POWER_DATA == 8'h00 && !BACK_TO_BACK_CAPABLE;
  endproperty
  a_zero: assert property (p_zero) else $error("field before load");
  property p_order;
    $rose(EE_REQ) && EE_ADDR != 6'h03 |-> EE_ADDR == ad_q + 6'h01;
  endproperty
  a_order: assert property (p_order) else $error("word order wrong");
  property p_last;
    $rose(LOAD_DONE) |-> ad_q == 6'h1F && !EE_REQ;
  endproperty
  a_last: assert property (p_last) else $error("done early");
  property p_rdata;
    !$past(REG_RD) |-> REG_RDATA == 16'h0000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("stray read data");
  c_done: cover property ($rose(LOAD_DONE));
  c_power: cover property ($rose(EE_REQ) && EE_ADDR == 6'h19);
  c_read: cover property (REG_RD ##1 REG_RDATA != 16'h0000);
endmodule
bind ecl_loader ecl_loader_asserts u_chk (.*);

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  localparam [15:0] BUS_W = 16'hA5C3;
  reg CLK, RESET_N, START, SLOW, REG_WR, REG_RD, CE;
  reg [3:0] REG_ADDR;
  reg [15:0] REG_WDATA, rd_v, sum;
  reg [13:0] rows [0:8];
  wire EE_REQ, EE_ACK, LOAD_DONE, CHECKSUM_OK, D1_SUPPORT, D2_SUPPORT;
  wire BACK_TO_BACK_CAPABLE, USER_FEATURES_FLAG, BELOW_ONE_MB_MAP;
  wire [5:0] EE_ADDR;
  wire [15:0] EE_DATA, REG_RDATA;
  wire [7:0] MIN_GRANT_FIELD, MAX_LATENCY_FIELD, POWER_DATA;
  wire [4:0] WAKE_SUPPORT_FIELD;
  wire [1:0] POWER_DATA_SCALE;
  integer miscompares, n_checks, i, cyc;
  ecl_loader u_dut (.*);
  ecl_ee_model u_ee (.*);
  initial begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end
  // ----
  // tasks
  // ----
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge CLK);
      REG_WR <= 1'h1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK);
      REG_WR <= 1'h0;
    end
  endtask
  task rd(input [3:0] a, input [15:0] e);
    begin
      @(posedge CLK);
      REG_RD <= 1'h1;
      REG_ADDR <= a;
      @(posedge CLK);
      REG_RD <= 1'h0;
      #1 chk(REG_RDATA, e);
    end
  endtask
  task load;
    integer k;
    begin
      @(posedge CLK);
      START <= 1'h1;
      @(posedge CLK);
      START <= 1'h0;
      for (k = 0; k < 3000 && LOAD_DONE !== 1'h1; k = k + 1) @(posedge CLK);
      repeat (3) @(posedge CLK);
      #1 chk({15'h0000, LOAD_DONE}, 16'h0001);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  initial begin
    {RESET_N, START, SLOW, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = 0;
    {miscompares, n_checks, cyc} = 0;
    CE = 1'h1;
    rows[0] = 14'h011F;
    rows[1] = 14'h051F;
    rows[2] = 14'h0915;
    rows[3] = 14'h0F11;
    rows[4] = 14'h111F;
    rows[5] = 14'h151F;
    rows[6] = 14'h1915;
    rows[7] = 14'h1F11;
    rows[8] = 14'h2100;
    for (i = 0; i < 64; i = i + 1) u_ee.mem[i] = 16'h5A00 ^ i;
    u_ee.mem[4] = {7'h63, 4'hC, 5'h1F};
    u_ee.mem[7] = 16'h4B52; // arbitrary maker word
    u_ee.mem[12] = BUS_W;
    u_ee.mem[25] = 16'h8D7E;
    sum = 16'h0000;
    for (i = 3; i < 31; i = i + 1) sum = sum ^ u_ee.mem[i];
    u_ee.mem[31] = sum;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'h1;
    @(posedge CLK);
    #1 chk({MIN_GRANT_FIELD, 7'h00, LOAD_DONE}, 16'h0000);
    load;
    chk({15'h0000, CHECKSUM_OK}, 16'h0001);
    chk({6'h00, WAKE_SUPPORT_FIELD, D2_SUPPORT, D1_SUPPORT, BELOW_ONE_MB_MAP,
      USER_FEATURES_FLAG, BACK_TO_BACK_CAPABLE},
      {6'h00, BUS_W[15:11], BUS_W[12:11], BUS_W[2:0]});
    chk({MAX_LATENCY_FIELD, MIN_GRANT_FIELD},
      {2'h0, BUS_W[10:7], 5'h00, BUS_W[6:3], 1'h0});
    for (i = 0; i < 9; i = i + 1) begin
      wr(4'h3, {12'h000, rows[i][13:10]});
      repeat (2) @(posedge CLK);
      #1 chk({8'h00, POWER_DATA}, {8'h00, rows[i][7:0]});
      chk({14'h0000, POWER_DATA_SCALE}, {14'h0000, rows[i][9:8]});
      rd(4'h4, {6'h00, rows[i][9:0]});
    end
    @(posedge CLK);
    CE <= 1'h0;
    wr(4'h3, 16'h0000);
    repeat (2) @(posedge CLK);
    #1 chk({8'h00, POWER_DATA}, 16'h0000);
    @(posedge CLK);
    CE <= 1'h1;
    rd(4'h0, 16'h0003);
    rd(4'h1, BUS_W);
    rd(4'h2, 16'h8D7E);
    rd(4'h5, u_ee.mem[4]);
    rd(4'h6, 16'h4B52);
    for (i = 0; i < 3; i = i + 1) begin
      rd(4'h7 + i, u_ee.mem[16 + i]);
      rd(4'h9 - i, u_ee.mem[18 - i]);
    end
    rd(4'hF, 16'h0000);
    wr(4'h1, 16'hFFFF);
    rd(4'h1, BUS_W);
    u_ee.mem[31] = sum ^ 16'h0001;
    @(posedge CLK);
    SLOW <= 1'h1;
    RESET_N <= 1'h0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'h1;
    @(posedge CLK);
    #1 chk({MAX_LATENCY_FIELD, 7'h00, LOAD_DONE}, 16'h0000);
    load;
    chk({15'h0000, CHECKSUM_OK}, 16'h0000);
    summarize;
  end
endmodule
